// [include/sr8_pkg.sv]
// Summary of operation
// - Each rising trigger edge samples serial input and shifts once.
// - A falling trigger edge does nothing; stages hold.
// - Direction low: bit enters stage_first, others move up, stage_last lost.
// - Direction high: bit enters stage_last, others move down, stage_first lost.
// - Output always shows the one configured stage, first to last.
// - Retentive option on: stage bits survive restart; the first reset after power-up clears them.
// - Retentive option off: restart from cleared stages after power loss.
// - Only one instance of this register per circuit program.
// - Stage selection fixed at program edit time, not changeable at run.
package sr8_pkg;
    localparam int SR8_STAGES = 8;
    localparam int SR8_SEL_W = 3;
    localparam logic [SR8_STAGES-1:0] SR8_STAGE_RST = 8'h00;
    localparam logic [SR8_SEL_W-1:0] SR8_SEL_FIRST = 3'h0;
    localparam int SR8_FIFO_DEPTH = 8;
    localparam logic SR8_DIR_UP = 1'b0;
endpackage

// [core/sr8_fifo.sv]
module sr8_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
            $error("sr8_fifo: depth must be a power of two of at least 2");
        end
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;
    logic in_ready_q, in_ready_d;

    always_comb begin
        push = in_valid && in_ready_q;
        pop = out_valid && out_ready;
        wr_d = push ? wr_q + AW'(1) : wr_q;
        rd_d = pop ? rd_q + AW'(1) : rd_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        in_ready_d = cnt_d != (AW+1)'(DEPTH);
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            in_ready_q <= 1'b1;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
            in_ready_q <= in_ready_d;
        end
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    // full flag registered from the next count, so in_ready leaves a flop
    assign in_ready = in_ready_q;
    assign out_valid = cnt_q != '0;
    assign out_data = mem_q[rd_q];

    a_fifo_no_overflow: assert property (@(posedge ref_clk) disable iff (srst)
        cnt_q == (AW+1)'(DEPTH) |-> !push) else $error("fifo push while full");
    a_fifo_ready_match: assert property (@(posedge ref_clk) disable iff (srst)
        in_ready == (cnt_q != (AW+1)'(DEPTH))) else $error("fifo ready flag off");
endmodule

// [core/sr8_shift_reg.sv]
module sr8_shift_reg
    import sr8_pkg::*;
#(
    parameter logic [sr8_pkg::SR8_SEL_W-1:0] STAGE_SEL = sr8_pkg::SR8_SEL_FIRST,
    parameter bit RETENTIVE = 1'b0,
    parameter int FIFO_DEPTH = sr8_pkg::SR8_FIFO_DEPTH
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // sampled inputs, one word per program cycle
    input wire logic in_valid,
    output logic in_ready,
    input wire logic trig,
    input wire logic ser_in,
    input wire logic shift_dir,
    // output
    output logic q_out,
    output logic [sr8_pkg::SR8_STAGES-1:0] stages
);
    import sr8_pkg::*;

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    // the selector must name one of the stages, the buffer must hold
    // at least two words; the single-instance limit is a usage rule
    // of the program and cannot be checked from inside one copy
    initial begin
        if (FIFO_DEPTH < 2) begin
            $error("sr8_shift_reg: fifo depth too small");
        end
        if (int'(STAGE_SEL) >= SR8_STAGES) begin
            $error("sr8_shift_reg: stage selector out of range");
        end
    end

    // ------------------------------------------------------------
    // input buffer
    // ------------------------------------------------------------
    logic f_valid, f_ready;
    logic [2:0] f_data;
    logic [2:0] in_word;
    assign in_word = {trig, ser_in, shift_dir};

    sr8_fifo #(.WIDTH(3), .DEPTH(FIFO_DEPTH)) u_fifo (
        .ref_clk(ref_clk),
        .srst(srst),
        .in_valid(in_valid),
        .in_ready(in_ready),
        .in_data(in_word),
        .out_valid(f_valid),
        .out_ready(f_ready),
        .out_data(f_data)
    );
    // one program cycle consumed per clock
    assign f_ready = 1'b1;

    // ------------------------------------------------------------
    // shift stages
    // ------------------------------------------------------------
    logic trig_prev_q, trig_prev_d;
    logic [SR8_STAGES-1:0] stage_q, stage_d;
    logic q_q, q_d;
    logic rise;

    // ------------------------------------------------------------
    // cold start
    // ------------------------------------------------------------
    // retained contents need a defined value at first power-up;
    // the first reset clears them, later restarts keep them
    logic cold_q = 1'b1;
    logic cold_d;

    always_comb begin
        cold_d = srst ? 1'b0 : cold_q;
    end

    always_ff @(posedge ref_clk) begin
        cold_q <= cold_d;
    end

    // stage_first is bit 0, stage_last is bit 7
    function automatic logic [SR8_STAGES-1:0] shift_once(
        input logic [SR8_STAGES-1:0] cur, input logic b, input logic dir);
        if (dir == SR8_DIR_UP) begin
            shift_once = {cur[SR8_STAGES-2:0], b};
        end else begin
            shift_once = {b, cur[SR8_STAGES-1:1]};
        end
    endfunction

    always_comb begin
        rise = f_valid && f_data[2] && !trig_prev_q;
        trig_prev_d = f_valid ? f_data[2] : trig_prev_q;
        stage_d = rise ? shift_once(stage_q, f_data[1], f_data[0]) : stage_q;
        q_d = stage_d[STAGE_SEL];
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            trig_prev_q <= 1'b0;
            // retentive contents survive a restart, otherwise cleared
            if (!RETENTIVE || cold_q) begin
                stage_q <= SR8_STAGE_RST;
                q_q <= 1'b0;
            end
        end else begin
            trig_prev_q <= trig_prev_d;
            stage_q <= stage_d;
            q_q <= q_d;
        end
    end

    assign q_out = q_q;
    assign stages = stage_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------

    a_shift_dir_up: assert property (@(posedge ref_clk) disable iff (srst)
        rise && f_data[0] == SR8_DIR_UP |=> stage_q[0] == $past(f_data[1])
            && stage_q[SR8_STAGES-1:1] == $past(stage_q[SR8_STAGES-2:0]))
        else $error("up shift wrong");
    a_shift_dir_dn: assert property (@(posedge ref_clk) disable iff (srst)
        rise && f_data[0] != SR8_DIR_UP |=> stage_q[SR8_STAGES-1] == $past(f_data[1])
            && stage_q[SR8_STAGES-2:0] == $past(stage_q[SR8_STAGES-1:1]))
        else $error("down shift wrong");
    a_hold_no_edge: assert property (@(posedge ref_clk) disable iff (srst)
        !rise |=> $stable(stage_q)) else $error("stages moved without edge");
    a_output_stage: assert property (@(posedge ref_clk) disable iff (srst)
        q_out == stage_q[STAGE_SEL]) else $error("output not selected stage");
    a_one_per_high: assert property (@(posedge ref_clk) disable iff (srst)
        rise |=> !(f_valid && f_data[2]) || !rise) else $error("double shift");
    a_clear_on_reset: assert property (@(posedge ref_clk)
        srst && (!RETENTIVE || cold_q) |=> stage_q == SR8_STAGE_RST && !q_q)
        else $error("stages not cleared by reset");
    a_keep_on_reset: assert property (@(posedge ref_clk)
        srst && RETENTIVE && !cold_q |=> stage_q == $past(stage_q))
        else $error("retained stages lost");
    a_fall_no_shift: assert property (@(posedge ref_clk) disable iff (srst)
        f_valid && !f_data[2] |=> $stable(stage_q))
        else $error("stages moved on low trigger");
    a_history_clear: assert property (@(posedge ref_clk)
        srst |=> !trig_prev_q) else $error("trigger history kept over reset");
    a_rise_takes_bit: assert property (@(posedge ref_clk) disable iff (srst)
        rise |=> stage_q != $past(stage_q) || $past(f_data[1]) == $past(stage_q[0])
            || $past(f_data[1]) == $past(stage_q[SR8_STAGES-1]))
        else $error("rising edge did not shift");
endmodule

// [tb/sr8_src.sv]
module sr8_src (
    // clock and handshake
    input wire logic ref_clk,
    input wire logic in_ready,
    // one word per program cycle
    output logic in_valid,
    output logic trig,
    output logic ser_in,
    output logic shift_dir
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        in_valid = 1'b0;
        {trig, ser_in, shift_dir} = 3'h0;
    end
    // word held until an edge with in_ready high takes it
    task automatic send(input logic t, input logic b, input logic d);
        @(negedge ref_clk);
        in_valid = 1'b1;
        {trig, ser_in, shift_dir} = {t, b, d};
        while (in_ready !== 1'b1) @(negedge ref_clk);
        @(posedge ref_clk);
        @(negedge ref_clk);
        in_valid = 1'b0;
        // stale bit is inverted so a late sample shows up
        ser_in = ~b;
    endtask
endmodule

// [tb/tb_sr8_shift_reg.sv]
module tb_sr8_shift_reg;
    timeunit 1ns;
    timeprecision 1ns;
    import sr8_pkg::*;
    // ----------------
    // bench
    // ----------------
    localparam logic [7:0] PAT = 8'hB4;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic in_valid, in_ready, in_ready_r, trig, ser_in, shift_dir, q_out, q_ret;
    logic [SR8_STAGES-1:0] stages, stages_r, exp;
    int n_fail = 0;
    int compares = 0;
    sr8_src u_sr8_src (.ref_clk, .in_ready, .in_valid, .trig, .ser_in, .shift_dir);
    sr8_shift_reg #(.STAGE_SEL(3'h7), .RETENTIVE(1'b0)) u_sr8_shift_reg (.ref_clk, .srst,
        .in_valid, .in_ready, .trig, .ser_in, .shift_dir, .q_out, .stages);
    // retentive twin on the same word stream, watching stage_first
    sr8_shift_reg #(.STAGE_SEL(3'h0), .RETENTIVE(1'b1)) u_sr8_shift_reg_ret (.ref_clk,
        .srst, .in_valid, .in_ready(in_ready_r), .trig, .ser_in, .shift_dir,
        .q_out(q_ret), .stages(stages_r));
    initial forever #10 ref_clk = ~ref_clk;
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        compares++;
        if (seen !== want) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic tally_and_finish();
        if (n_fail == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // low word, rising word, repeated high word
    task automatic shift_one(input logic b, input logic d);
        u_sr8_src.send(1'b0, ~b, d);
        u_sr8_src.send(1'b1, b, d);
        u_sr8_src.send(1'b1, ~b, d);
        exp = d ? {b, exp[7:1]} : {exp[6:0], b};
        repeat (3) @(negedge ref_clk);
        check(stages, exp);
        check({7'h00, q_out}, {7'h00, exp[7]});
    endtask
    task automatic test_shifts();
        // eight up shifts fill the retentive twin before any down shift
        for (int i = 0; i < 11; i++)
            shift_one(PAT[i % 8], i >= 8);
    endtask
    task automatic test_mid_reset();
        @(negedge ref_clk);
        srst = 1'b1;
        @(negedge ref_clk);
        srst = 1'b0;
        check(stages, 8'h00);
        check({7'h00, q_out}, 8'h00);
        check(stages_r, exp);
        check({7'h00, q_ret}, {7'h00, exp[0]});
        // trigger history cleared, so a first high word is a rising edge
        u_sr8_src.send(1'b1, 1'b1, SR8_DIR_UP);
        repeat (3) @(negedge ref_clk);
        check(stages, 8'h01);
    endtask
    initial begin
        exp = SR8_STAGE_RST;
        repeat (6) @(negedge ref_clk);
        srst = 1'b0;
        check(stages, 8'h00);
        test_shifts();
        test_mid_reset();
        tally_and_finish();
    end
    initial begin
        #100000;
        n_fail++;
        tally_and_finish();
    end
endmodule
